// [tcs_trigger_switch.sv]
`timescale 1ns/1ps
`default_nettype none
module tcs_trigger_switch #(
  parameter bit DUAL_PATH = 1'b1,
  parameter int SCRUB_TICK_CYCLES = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cbus_sel,
  input wire logic cbus_write,
  input wire logic [5:0] cbus_addr,
  input wire logic [7:0] cbus_wdata,
  output logic [7:0] cbus_rdata_q,
  output logic cbus_ack_q,
  input wire logic [4:0] trig_cond,
  input wire logic [4:0] trig_en,
  input wire logic scrub_enable,
  input wire logic [2:0] transmit_mode_field,
  input wire logic [9:0] invalid_bus,
  input wire logic [9:0] receiver_bus,
  input wire logic [9:0] first_req_bus,
  input wire logic [9:0] second_req_bus,
  output logic first_port_parity,
  output logic first_port_control,
  output logic [7:0] first_port_bus,
  output logic first_port_oe,
  output logic second_port_parity,
  output logic second_port_control,
  output logic [7:0] second_port_bus,
  output logic second_port_oe,
  output logic [9:0] tx_source_q,
  output logic tx_idle_q,
  output logic scrubbing_q,
  output logic trigger_q
);
  logic [7:0] shadow_q;
  logic [7:0] live_switch_config;
  logic [7:0] scrub_duration_threshold;
  logic cond_q;
  logic cond_any;
  logic trig_pulse;
  logic wr_en;
  logic [7:0] scrub_left_q;
  logic [15:0] tick_q;
  logic tick;
  logic [9:0] first_src;
  logic [9:0] second_src;
  logic [9:0] tx_src;
  logic [9:0] src_mux [3];

  function automatic logic [9:0] pick(
    input logic [1:0] sel,
    input logic [9:0] inv,
    input logic [9:0] rcv,
    input logic [9:0] fr,
    input logic [9:0] sr
  );
    unique case (tcs_pkg::tcs_src_t'(sel))
      tcs_pkg::SRC_INVALID: pick = inv;
      tcs_pkg::SRC_RECEIVER: pick = rcv;
      tcs_pkg::SRC_FIRST_REQ: pick = fr;
      tcs_pkg::SRC_SECOND_REQ: pick = sr;
    endcase
  endfunction

  assign wr_en = cbus_sel & cbus_write;
  // only the rising edge counts, so a condition that stays true reloads once
  assign cond_any = |(trig_cond & trig_en);
  assign trig_pulse = cond_any & ~cond_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cond_q <= 1'b0;
      trigger_q <= 1'b0;
    end else begin
      cond_q <= cond_any;
      trigger_q <= trig_pulse;
    end
  end

  // only software writes the shadow; a trigger reads it but never clears it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shadow_q <= tcs_pkg::SHADOW_RESET;
    end else if (wr_en && cbus_addr == tcs_pkg::SHADOW_ADDR) begin
      shadow_q <= cbus_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scrub_duration_threshold <= tcs_pkg::SCRUB_THRESH_RESET;
    end else if (wr_en && cbus_addr == tcs_pkg::SCRUB_THRESH_ADDR) begin
      scrub_duration_threshold <= cbus_wdata;
    end
  end

  // trigger beats a same-cycle software write so the loaded setting is always the shadow's
  // a software write to the live register takes effect at once, bypassing the shadow
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      live_switch_config <= tcs_pkg::LIVE_RESET;
    end else if (trig_pulse) begin
      live_switch_config <= shadow_q;
    end else if (wr_en && cbus_addr == tcs_pkg::LIVE_SWITCH_ADDR) begin
      live_switch_config <= cbus_wdata;
    end
  end

  // read data is zero outside the answer cycle, so a late sample never shows a stale byte
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cbus_ack_q <= 1'b0;
      cbus_rdata_q <= 8'h00;
    end else begin
      cbus_ack_q <= cbus_sel;
      if (cbus_sel && !cbus_write) begin
        unique case (cbus_addr)
          tcs_pkg::SHADOW_ADDR: cbus_rdata_q <= shadow_q;
          tcs_pkg::LIVE_SWITCH_ADDR: cbus_rdata_q <= live_switch_config;
          tcs_pkg::SCRUB_THRESH_ADDR: cbus_rdata_q <= scrub_duration_threshold;
          default: cbus_rdata_q <= 8'h00;
        endcase
      end else begin
        cbus_rdata_q <= 8'h00;
      end
    end
  end

  // scrub duration is counted in ticks of SCRUB_TICK_CYCLES clocks
  // limitation: a tick longer than 65536 clocks would wrap the 16-bit tick counter
  assign tick = (tick_q == 16'(SCRUB_TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 16'h0000;
    end else if (trig_pulse || tick) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end

  // a zero threshold scrubs nothing even with scrubbing enabled; a new trigger restarts the count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scrub_left_q <= 8'h00;
      scrubbing_q <= 1'b0;
    end else if (trig_pulse) begin
      scrub_left_q <= scrub_enable ? scrub_duration_threshold : 8'h00;
      scrubbing_q <= scrub_enable && (scrub_duration_threshold != 8'h00);
    end else if (tick && scrub_left_q != 8'h00) begin
      scrub_left_q <= scrub_left_q - 8'h01;
      scrubbing_q <= (scrub_left_q != 8'h01);
    end
  end

  // one four-way mux per selector field: 0 first port, 1 second port, 2 transmitter
  for (genvar g = 0; g < 3; g++) begin : g_src
    localparam int LSB = (g == 0) ? tcs_pkg::FIRST_SEL_LSB :
                         (g == 1) ? tcs_pkg::SECOND_SEL_LSB : tcs_pkg::TX_SEL_LSB;
    assign src_mux[g] = pick(live_switch_config[LSB +: 2], invalid_bus, receiver_bus, first_req_bus,
                             second_req_bus);
  end

  assign first_src = src_mux[0];
  assign second_src = src_mux[1];
  assign tx_src = src_mux[2];

  // a disabled port drives zero behind a low enable, so the pin floats outside this block
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      first_port_parity <= 1'b0;
      first_port_control <= 1'b0;
      first_port_bus <= 8'h00;
      first_port_oe <= 1'b0;
    end else begin
      first_port_oe <= live_switch_config[tcs_pkg::FIRST_EN_BIT];
      {first_port_parity, first_port_control, first_port_bus} <=
        live_switch_config[tcs_pkg::FIRST_EN_BIT] ? first_src : 10'h000;
    end
  end

  // the single-path part still stores the second-port bits; only its pins stay quiet
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      second_port_parity <= 1'b0;
      second_port_control <= 1'b0;
      second_port_bus <= 8'h00;
      second_port_oe <= 1'b0;
    end else begin
      second_port_oe <= DUAL_PATH && live_switch_config[tcs_pkg::SECOND_EN_BIT];
      {second_port_parity, second_port_control, second_port_bus} <=
        (DUAL_PATH && live_switch_config[tcs_pkg::SECOND_EN_BIT]) ? second_src : 10'h000;
    end
  end

  // idle follows the live selector and the mode as they stand, so a mode change needs no trigger
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_source_q <= 10'h000;
      tx_idle_q <= 1'b0;
    end else begin
      tx_source_q <= tx_src;
      tx_idle_q <= (transmit_mode_field == tcs_pkg::TM_ACTIVE) &&
                   (live_switch_config[tcs_pkg::TX_SEL_LSB +: 2] == 2'(tcs_pkg::SRC_INVALID));
    end
  end
endmodule
`default_nettype wire

// [tcs_pkg.sv]
package tcs_pkg;
  localparam logic [5:0] LIVE_SWITCH_ADDR = 6'h01;
  localparam logic [5:0] SCRUB_THRESH_ADDR = 6'h26;
  localparam logic [5:0] SHADOW_ADDR = 6'h27;
  localparam logic [7:0] SHADOW_RESET = 8'h00;
  localparam logic [7:0] LIVE_RESET = 8'h00;
  localparam logic [7:0] SCRUB_THRESH_RESET = 8'h00;
  localparam int FIRST_SEL_LSB = 0;
  localparam int SECOND_SEL_LSB = 2;
  localparam int TX_SEL_LSB = 4;
  localparam int FIRST_EN_BIT = 6;
  localparam int SECOND_EN_BIT = 7;
  localparam logic [2:0] TM_ACTIVE = 3'h0;
  localparam int NUM_TRIG = 5;
  typedef enum logic [1:0] {
    SRC_INVALID = 2'b00,
    SRC_RECEIVER = 2'b01,
    SRC_FIRST_REQ = 2'b10,
    SRC_SECOND_REQ = 2'b11
  } tcs_src_t;
endpackage

// [tcs_mac_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tcs_mac_model (
  input wire logic clock,
  input wire logic [9:0] word,
  output logic [9:0] first_req_bus,
  output logic [9:0] second_req_bus
);
  // the two request buses never carry the same word, so a swapped select shows up
  always_ff @(posedge clock) begin
    first_req_bus <= word;
    second_req_bus <= ~word;
  end
endmodule
`default_nettype wire

// [tcs_trigger_switch_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module tcs_trigger_switch_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cbus_sel,
  input wire logic cbus_write,
  input wire logic [5:0] cbus_addr,
  input wire logic [4:0] trig_cond,
  input wire logic [4:0] trig_en,
  input wire logic [2:0] transmit_mode_field,
  input wire logic [9:0] invalid_bus,
  input wire logic [7:0] first_port_bus,
  input wire logic first_port_oe,
  input wire logic [7:0] second_port_bus,
  input wire logic second_port_oe,
  input wire logic [9:0] tx_source_q,
  input wire logic tx_idle_q,
  input wire logic scrubbing_q,
  input wire logic trigger_q
);
  logic live_wr;
  // a software write to the live register is the only other way the enables may move
  assign live_wr = cbus_sel && cbus_write && (cbus_addr == tcs_pkg::LIVE_SWITCH_ADDR);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  trig_answer_a: assert property ($rose(|(trig_cond & trig_en)) |-> ##[1:2] trigger_q)
    else $error("no trigger pulse after enabled condition");
  trig_pulse_a: assert property (trigger_q |=> !trigger_q)
    else $error("trigger pulse longer than one cycle");
  first_float_a: assert property (!first_port_oe |-> first_port_bus == 8'h00)
    else $error("first port data while disabled");
  second_float_a: assert property (!second_port_oe |-> second_port_bus == 8'h00)
    else $error("second port data while disabled");
  idle_mode_a: assert property (tx_idle_q |-> $past(transmit_mode_field) == tcs_pkg::TM_ACTIVE)
    else $error("idle sent outside active transmit");
  idle_source_a: assert property (tx_idle_q |-> tx_source_q == $past(invalid_bus))
    else $error("idle without invalid bus selected");
  oe_on_trig_a: assert property ($changed(first_port_oe) |-> $past(trigger_q) || $past(live_wr, 2))
    else $error("port enable changed without trigger");
  scrub_start_a: assert property ($rose(scrubbing_q) |-> trigger_q || $past(trigger_q))
    else $error("scrubbing started without trigger");
  cover property (trigger_q && first_port_oe && second_port_oe);
  cover property (tx_idle_q);
  cover property ($fell(scrubbing_q));
endmodule
bind tcs_trigger_switch tcs_trigger_switch_chk tcs_trigger_switch_chk_inst (.*);
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, rst_b = 1'b0, cbus_sel = 1'b0, cbus_write = 1'b0, scrub_enable = 1'b1;
  logic [5:0] cbus_addr = 6'h00;
  logic [7:0] cbus_wdata = 8'h00, cbus_rdata_q, first_port_bus, second_port_bus, r, d;
  logic [4:0] trig_cond = 5'h00, trig_en = 5'h1f;
  logic [2:0] transmit_mode_field = 3'h0;
  logic [9:0] invalid_bus = 10'h155, receiver_bus = 10'h0aa, word = 10'h3c3, first_req_bus, second_req_bus, tx_source_q;
  logic cbus_ack_q, first_port_parity, first_port_control, first_port_oe, second_port_parity, second_port_control;
  logic second_port_oe, tx_idle_q, scrubbing_q, trigger_q;
  int mismatches = 0, n_tests = 0, seed = 32'h10d1, i;
  tcs_trigger_switch tcs_trigger_switch_inst (.*);
  tcs_mac_model tcs_mac_model_inst (.*);
  always #20 clock = ~clock;
  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] v);
    @(posedge clock);
    cbus_sel <= 1'b1;
    cbus_write <= w;
    cbus_addr <= a;
    cbus_wdata <= v;
    @(posedge clock);
    cbus_sel <= 1'b0;
    #1 r = cbus_rdata_q;
    cmp("ack", 10'h001, {9'h000, cbus_ack_q});
  endtask
  // one-cycle condition pulse on a random enabled line, so every trigger source gets a turn
  task automatic fire;
    @(posedge clock);
    trig_cond <= 5'h01 << ($unsigned($random(seed)) % 5);
    @(posedge clock);
    trig_cond <= 5'h00;
    #1 cmp("trigger", 10'h001, {9'h000, trigger_q});
    repeat (2) @(posedge clock);
    #1;
  endtask
  function automatic logic [9:0] pick(input logic [1:0] s);
    case (s)
      2'b00: pick = invalid_bus;
      2'b01: pick = receiver_bus;
      2'b10: pick = word;
      default: pick = ~word;
    endcase
  endfunction
  task automatic conclude;
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    acc(1'b0, tcs_pkg::SHADOW_ADDR, 8'h00);
    cmp("shadow_reset", {2'b00, tcs_pkg::SHADOW_RESET}, r);
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      word <= 10'($random(seed));
      invalid_bus <= 10'($random(seed));
      receiver_bus <= 10'($random(seed));
      transmit_mode_field <= i[0] ? 3'h0 : 3'($random(seed));
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
      acc(1'b1, tcs_pkg::SHADOW_ADDR, d);
      acc(1'b0, tcs_pkg::SHADOW_ADDR, 8'h00);
      cmp("shadow", {2'b00, d}, r);
      fire;
      cmp("first_port", d[6] ? pick(d[1:0]) : 10'h000, {first_port_parity, first_port_control, first_port_bus});
      cmp("first_oe", {9'h000, d[6]}, {9'h000, first_port_oe});
      cmp("second_port", d[7] ? pick(d[3:2]) : 10'h000, {second_port_parity, second_port_control, second_port_bus});
      cmp("second_oe", {9'h000, d[7]}, {9'h000, second_port_oe});
      cmp("tx_source", pick(d[5:4]), tx_source_q);
      cmp("tx_idle", {9'h000, d[5:4] == 2'b00 && transmit_mode_field == tcs_pkg::TM_ACTIVE}, {9'h000, tx_idle_q});
      cmp("scrub_zero", 10'h000, {9'h000, scrubbing_q});
      acc(1'b0, tcs_pkg::LIVE_SWITCH_ADDR, 8'h00);
      cmp("live", {2'b00, d}, r);
    end
    acc(1'b1, tcs_pkg::SCRUB_THRESH_ADDR, 8'h08);
    fire;
    cmp("scrub_on", 10'h001, {9'h000, scrubbing_q});
    repeat (5) @(posedge clock);
    #1 cmp("scrub_hold", 10'h001, {9'h000, scrubbing_q});
    @(posedge clock);
    #1 cmp("scrub_off", 10'h000, {9'h000, scrubbing_q});
    @(posedge clock);
    scrub_enable <= 1'b0;
    fire;
    cmp("scrub_disabled", 10'h000, {9'h000, scrubbing_q});
    // a condition on a masked line must not raise trigger_q
    @(posedge clock);
    trig_en <= 5'h1e;
    trig_cond <= 5'h01;
    @(posedge clock);
    trig_cond <= 5'h00;
    #1 cmp("masked_trigger", 10'h000, {9'h000, trigger_q});
    @(posedge clock);
    trig_en <= 5'h1f;
    acc(1'b1, tcs_pkg::LIVE_SWITCH_ADDR, 8'h40);
    acc(1'b0, tcs_pkg::LIVE_SWITCH_ADDR, 8'h00);
    cmp("live_write", 10'h040, {2'b00, r});
    cmp("live_oe", 10'h001, {9'h000, first_port_oe});
    acc(1'b0, 6'h3f, 8'h00);
    cmp("unmapped", 10'h000, {2'b00, r});
    conclude;
  end
endmodule
`default_nettype wire
